// file: hdl/dual_pot_pkg.sv
/*
 Constants, types and structs shared by the dual potentiometer slave.
 Assumes a 125 MHz system clock and the serial clock as the link clock.
*/
// What this block does
// RQ1 - Seven-bit wiper code, 00h low, 7Fh high
// RQ2 - Preset wipers 40h, then recall initial values
// RQ3 - Address 00h channel 0, 01h channel 1
// RQ4 - Spare bytes 2..6, reserved 7, control at 8
// RQ5 - Volatile-select bit picks wiper or initial value
// RQ6 - Initial value writes also update the wiper
// RQ7 - Volatile-select bit reads 0 after power-up
// RQ8 - Run bit ANDed with power-down pin, default 1
// RQ9 - Shutdown opens high end, wiper to low
// RQ10 - Serial port and registers live during shutdown
// RQ11 - Busy bit set during storage write, blocks writes
// RQ12 - Bytes travel most significant bit first
// RQ13 - Data moves only while clock is low
// RQ14 - Ignore bus until start; ignore during power-up
// RQ15 - Stop returns the slave to idle
// RQ16 - Ninth clock is the acknowledge slot
// RQ17 - Acknowledge id, address and written bytes
// RQ18 - Id byte: prefix, strap pins, direction bit
// RQ19 - Sample on rising edge, drive after falling
// RQ20 - Data pin released after power-up
// RQ21 - Pointer increments per byte, wraps after 08h
// RQ22 - Master reads via address write, repeated start
// RQ23 - Storage write after stop, one per transaction
// RQ24 - Low control bits and reserved byte read zero
// RQ25 - No acknowledge on mismatching id byte

package dual_pot_pkg;
   localparam int CLK_MHZ      = 125;
   localparam int NV_WRITE_US  = 20000;
   localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
   localparam int NV_SETTLE_US = 1;
   localparam int SETTLE_CYC   = NV_SETTLE_US * CLK_MHZ;

   // Arbitrary device-type prefix
   localparam logic [3:0] ID_PREFIX     = 4'h6;
   localparam logic [3:0] ADDR_POT0     = 4'h0;
   localparam logic [3:0] ADDR_POT1     = 4'h1;
   localparam logic [3:0] ADDR_GP_FIRST = 4'h2;
   localparam logic [3:0] ADDR_GP_LAST  = 4'h6;
   localparam logic [3:0] ADDR_RSVD     = 4'h7;
   localparam logic [3:0] ADDR_ACR      = 4'h8;

   localparam int ACR_VOL_BIT  = 7;
   localparam int ACR_RUN_BIT  = 6;
   localparam int ACR_BUSY_BIT = 5;
   localparam logic ACR_VOL_RST = 1'b0;
   localparam logic ACR_RUN_RST = 1'b1;

   localparam logic [6:0] WIPER_PRESET = 7'h40;
   localparam logic [7:0] NV_BLANK     = 8'h40;
   localparam logic [3:0] BIT_LAST     = 4'h7;
   localparam logic [3:0] BIT_ACK      = 4'h8;

   typedef enum logic [1:0] {
      EVT_ADDR  = 2'h0,
      EVT_WDATA = 2'h1,
      EVT_RDATA = 2'h2
   } evt_kind_type;

   typedef struct packed {
      evt_kind_type kind;
      logic [7:0]   data;
   } link_evt_type;

   typedef struct packed {
      logic       run;
      logic [6:0] tap1;
      logic [6:0] tap0;
   } pot_ctrl_type;

   typedef enum logic [2:0] {
      PWR_PRESET = 3'b000,
      PWR_SETTLE = 3'b001,
      PWR_LOAD0  = 3'b011,
      PWR_LOAD1  = 3'b010,
      PWR_LOAD2  = 3'b110,
      PWR_READY  = 3'b111
   } pwr_state_type;

   typedef enum logic [2:0] {
      LNK_ID     = 3'b000,
      LNK_ADDR   = 3'b001,
      LNK_WDATA  = 3'b011,
      LNK_RDATA  = 3'b010,
      LNK_IGNORE = 3'b110
   } link_state_type;
endpackage

// file: hdl/nv_store.sv
/*
 Non-volatile byte store: eight cells, one write port, registered read.
 Assumes writes are rare single pulses from the register logic.
*/
`timescale 1ns/1ps
module nv_store
   import dual_pot_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       wr_en_i,
   input  wire logic [2:0] wr_addr_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic [2:0] rd_addr_i,
   output logic      [7:0] rd_data_o
);
   import dual_pot_pkg::*;
   logic [7:0] cell_ff [8];

   // Cells come up blank; a real part keeps them over power cycles
   for (genvar i = 0; i < 8; i++)
   begin : g_cell
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
         if (!rstn_i)
            cell_ff[i] <= NV_BLANK;
         else if (wr_en_i && wr_addr_i == 3'(i))
            cell_ff[i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rd_data_o <= 8'h00;
      else
         rd_data_o <= cell_ff[rd_addr_i];
   end
endmodule

// file: hdl/dual_pot_slave.sv
/*
 Two-wire slave and register file of a dual digital potentiometer.
 Assumes the serial clock drives scl_i as a clock and the master keeps
 the two-wire protocol; the other pins are asynchronous.
*/
`timescale 1ns/1ps
module dual_pot_slave
   import dual_pot_pkg::*;
#(
   parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
)
(
   input  wire logic                      clk_i,
   input  wire logic                      rstn_i,
   input  wire logic                      scl_i,
   input  wire logic                      sda_i,
   output logic                           sda_o,
   output logic                           sda_oe_o,
   input  wire logic [2:0]                addr_strap_pins_i,
   input  wire logic                      run_enable_n_i,
   output dual_pot_pkg::pot_ctrl_type     pot_ctrl_o
);
   import dual_pot_pkg::*;

   function automatic logic is_nv(input logic [3:0] a, input logic volatile_select);
      is_nv = (a <= ADDR_POT1) ? !volatile_select
                               : (a >= ADDR_GP_FIRST && a <= ADDR_GP_LAST);
   endfunction

   // ***************************************************************
   // Pin synchronisers (system clock)
   // ***************************************************************
   logic [5:0] pin_s1_ff;
   logic [5:0] pin_s2_ff;
   logic       scl_d_ff;
   logic       sda_d_ff;
   logic       scl_s;
   logic       sda_s;
   logic       pin_run_s;
   logic [2:0] strap_s;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pin_s1_ff <= 6'h3f;
         pin_s2_ff <= 6'h3f;
         scl_d_ff  <= 1'b1;
         sda_d_ff  <= 1'b1;
      end
      else
      begin
         pin_s1_ff <= {scl_i, sda_i, run_enable_n_i, addr_strap_pins_i};
         pin_s2_ff <= pin_s1_ff;
         scl_d_ff  <= pin_s2_ff[5];
         sda_d_ff  <= pin_s2_ff[4];
      end
   end

   assign scl_s     = pin_s2_ff[5];
   assign sda_s     = pin_s2_ff[4];
   assign pin_run_s = pin_s2_ff[3];
   assign strap_s   = pin_s2_ff[2:0];

   // ***************************************************************
   // Start and stop detection, link reset
   // ***************************************************************
   pwr_state_type pwr_ff;
   logic          ready;
   logic          start_det;
   logic          stop_det;
   logic          in_frame_ff;
   logic          restart_ff;
   logic          link_rst_n;

   assign ready     = (pwr_ff == PWR_READY);
   assign start_det = ready && scl_s && scl_d_ff
                      && sda_d_ff && !sda_s; // [RQ14]
   assign stop_det  = scl_s && scl_d_ff && !sda_d_ff && sda_s;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         in_frame_ff <= 1'b0;
      else if (start_det)
         in_frame_ff <= 1'b1;
      else if (stop_det)
         in_frame_ff <= 1'b0;
   end

   // Link logic held idle until a start, released only while SCL is low
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         restart_ff <= 1'b1;
      else if (start_det || stop_det)
         restart_ff <= 1'b1; // [RQ15]
      else if (in_frame_ff && !scl_s)
         restart_ff <= 1'b0;
   end

   assign link_rst_n = rstn_i && !restart_ff;

   // ***************************************************************
   // Link side (serial clock)
   // ***************************************************************
   logic [3:0]     cnt_ff;
   logic [7:0]     sh_ff;
   link_state_type lstate_ff;
   logic           ack_ff;
   link_evt_type   evt_ff;
   logic           evt_tgl_ff;
   logic [7:0]     tx_ff;
   logic           sda_oe_ff;
   logic [7:0]     rd_byte_ff;
   logic [7:0]     in_byte;
   logic           byte_done;
   logic           id_match;

   assign in_byte   = {sh_ff[6:0], sda_i}; // [RQ12]
   assign byte_done = (cnt_ff == BIT_LAST);
   assign id_match  = (in_byte[7:1] == {ID_PREFIX, strap_s}); // [RQ18]

   always_ff @(posedge scl_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         cnt_ff <= 4'h0;
         sh_ff  <= 8'h00;
      end
      else if (cnt_ff == BIT_ACK)
         cnt_ff <= 4'h0;
      else
      begin
         cnt_ff <= cnt_ff + 4'h1;
         sh_ff  <= in_byte; // [RQ19]
      end
   end

   always_ff @(posedge scl_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         lstate_ff <= LNK_ID;
         ack_ff    <= 1'b0;
      end
      else if (cnt_ff == BIT_ACK)
      begin
         ack_ff <= 1'b0;
         if (lstate_ff == LNK_RDATA && sda_i)
            lstate_ff <= LNK_IGNORE;
      end
      else if (byte_done)
      begin
         case (lstate_ff)
            LNK_ID:
            begin
               ack_ff    <= id_match; // [RQ17] [RQ25]
               lstate_ff <= !id_match ? LNK_IGNORE
                          : in_byte[0] ? LNK_RDATA : LNK_ADDR;
            end
            LNK_ADDR:
            begin
               ack_ff    <= (in_byte <= {4'h0, ADDR_ACR}); // [RQ17]
               lstate_ff <= (in_byte <= {4'h0, ADDR_ACR}) ? LNK_WDATA
                                                          : LNK_IGNORE;
            end
            LNK_WDATA:
               ack_ff <= 1'b1; // [RQ17]
            default:
               ack_ff <= 1'b0;
         endcase
      end
   end

   // Toggle skips the link reset, else a restart would fake an event
   always_ff @(posedge scl_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         evt_ff     <= '0;
         evt_tgl_ff <= 1'b0;
      end
      else if (byte_done && lstate_ff != LNK_ID
               && lstate_ff != LNK_IGNORE)
      begin
         if (lstate_ff != LNK_ADDR || in_byte <= {4'h0, ADDR_ACR})
         begin
            evt_ff.data <= in_byte;
            evt_ff.kind <= (lstate_ff == LNK_ADDR)  ? EVT_ADDR
                         : (lstate_ff == LNK_WDATA) ? EVT_WDATA
                                                    : EVT_RDATA;
            evt_tgl_ff  <= !evt_tgl_ff;
         end
      end
   end

   // Output changes only after a falling edge, so never while SCL high
   always_ff @(negedge scl_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         sda_oe_ff <= 1'b0; // [RQ20]
         tx_ff     <= 8'h00;
      end
      else if (cnt_ff == BIT_ACK)
         sda_oe_ff <= ack_ff; // [RQ16]
      else if (lstate_ff == LNK_RDATA && cnt_ff == 4'h0)
      begin
         tx_ff     <= {rd_byte_ff[6:0], 1'b0};
         sda_oe_ff <= !rd_byte_ff[7]; // [RQ12] [RQ19] [RQ13]
      end
      else if (lstate_ff == LNK_RDATA)
      begin
         tx_ff     <= {tx_ff[6:0], 1'b0};
         sda_oe_ff <= !tx_ff[7];
      end
      else
         sda_oe_ff <= 1'b0;
   end

   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_oe_ff;

   // ***************************************************************
   // Event crossing into the system clock
   // ***************************************************************
   logic [2:0] evt_sync_ff;
   logic       evt_new;
   logic       wr_evt;
   logic       wr_ok;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         evt_sync_ff <= 3'h0;
      else
         evt_sync_ff <= {evt_sync_ff[1:0], evt_tgl_ff};
   end

   assign evt_new = evt_sync_ff[2] ^ evt_sync_ff[1];
   assign wr_evt  = evt_new && evt_ff.kind == EVT_WDATA;

   // ***************************************************************
   // Power-up, registers and storage writes
   // ***************************************************************
   logic [6:0]  wiper_ff [2];
   logic        vol_ff;
   logic        run_ff;
   logic        busy_ff;
   logic [21:0] busy_cnt_ff;
   logic [7:0]  settle_cnt_ff;
   logic [3:0]  ptr_ff;
   logic        nv_pend_ff;
   logic [2:0]  nv_addr_ff;
   logic [7:0]  nv_data_ff;
   logic [7:0]  mem_rdata;
   logic [2:0]  mem_raddr;
   logic        nv_commit;
   logic [7:0]  nxt_rd_byte;
   pot_ctrl_type pot_ctrl_ff;

   assign wr_ok     = wr_evt && !busy_ff; // [RQ11]
   assign nv_commit = stop_det && nv_pend_ff; // [RQ23]
   assign mem_raddr = (pwr_ff == PWR_LOAD0) ? 3'h0
                    : (pwr_ff == PWR_LOAD1) ? 3'h1 : ptr_ff[2:0];

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pwr_ff        <= PWR_PRESET;
         settle_cnt_ff <= 8'h00;
      end
      else
      begin
         case (pwr_ff)
            PWR_PRESET: pwr_ff <= PWR_SETTLE;
            PWR_SETTLE:
            begin
               settle_cnt_ff <= settle_cnt_ff + 8'h01;
               if (settle_cnt_ff == 8'(SETTLE_CYC - 1))
                  pwr_ff <= PWR_LOAD0;
            end
            PWR_LOAD0: pwr_ff <= PWR_LOAD1;
            PWR_LOAD1: pwr_ff <= PWR_LOAD2;
            PWR_LOAD2: pwr_ff <= PWR_READY;
            default:   pwr_ff <= PWR_READY;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wiper_ff[0] <= WIPER_PRESET; // [RQ2]
         wiper_ff[1] <= WIPER_PRESET;
      end
      else if (pwr_ff == PWR_LOAD1)
         wiper_ff[0] <= mem_rdata[6:0]; // [RQ2]
      else if (pwr_ff == PWR_LOAD2)
         wiper_ff[1] <= mem_rdata[6:0];
      else if (wr_ok && ptr_ff <= ADDR_POT1)
         wiper_ff[ptr_ff[0]] <= evt_ff.data[6:0]; // [RQ1] [RQ3] [RQ6]
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         vol_ff <= ACR_VOL_RST; // [RQ7]
         run_ff <= ACR_RUN_RST; // [RQ8]
      end
      else if (wr_ok && ptr_ff == ADDR_ACR)
      begin
         vol_ff <= evt_ff.data[ACR_VOL_BIT];
         run_ff <= evt_ff.data[ACR_RUN_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ptr_ff <= ADDR_POT0;
      else if (evt_new && evt_ff.kind == EVT_ADDR)
         ptr_ff <= evt_ff.data[3:0]; // [RQ3]
      else if (evt_new)
         ptr_ff <= (ptr_ff == ADDR_ACR) ? ADDR_POT0
                                        : ptr_ff + 4'h1; // [RQ21]
   end

   // Last storage write of a transaction wins
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         nv_pend_ff <= 1'b0;
         nv_addr_ff <= 3'h0;
         nv_data_ff <= 8'h00;
      end
      else if (wr_ok && is_nv(ptr_ff, vol_ff)) // [RQ5] [RQ4]
      begin
         nv_pend_ff <= 1'b1;
         nv_addr_ff <= ptr_ff[2:0];
         nv_data_ff <= evt_ff.data;
      end
      else if (stop_det)
         nv_pend_ff <= 1'b0;
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         busy_ff     <= 1'b0;
         busy_cnt_ff <= 22'h000000;
      end
      else if (nv_commit)
      begin
         busy_ff     <= 1'b1; // [RQ11] [RQ23]
         busy_cnt_ff <= 22'(NV_WRITE_CYCLES - 1);
      end
      else if (busy_cnt_ff != 22'h000000)
         busy_cnt_ff <= busy_cnt_ff - 22'h000001;
      else
         busy_ff <= 1'b0;
   end

   nv_store u_store (
      .clk_i     (clk_i),
      .rstn_i    (rstn_i),
      .wr_en_i   (nv_commit),
      .wr_addr_i (nv_addr_ff),
      .wr_data_i (nv_data_ff),
      .rd_addr_i (mem_raddr),
      .rd_data_o (mem_rdata)
   );

   always_comb
   begin
      nxt_rd_byte = 8'h00; // [RQ24]
      if (ptr_ff <= ADDR_POT1)
         nxt_rd_byte = vol_ff ? {1'b0, wiper_ff[ptr_ff[0]]}
                              : mem_rdata; // [RQ5]
      else if (is_nv(ptr_ff, vol_ff))
         nxt_rd_byte = mem_rdata; // [RQ4]
      else if (ptr_ff == ADDR_ACR)
      begin
         nxt_rd_byte[ACR_VOL_BIT]  = vol_ff;
         nxt_rd_byte[ACR_RUN_BIT]  = run_ff;
         nxt_rd_byte[ACR_BUSY_BIT] = busy_ff; // [RQ11]
      end
   end

   // Read byte is quasi-static for the link: it settles in a few system
   // clocks, long before the next falling SCL edge loads it
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rd_byte_ff <= 8'h00;
      else
         rd_byte_ff <= nxt_rd_byte;
   end

   // Registers stay reachable in shutdown; only the analog side idles
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pot_ctrl_ff <= '0;
      else
      begin
         pot_ctrl_ff.run  <= pin_run_s && run_ff; // [RQ8] [RQ10]
         pot_ctrl_ff.tap0 <= (pin_run_s && run_ff) ? wiper_ff[0] : 7'h00;
         pot_ctrl_ff.tap1 <= (pin_run_s && run_ff) ? wiper_ff[1] : 7'h00;
      end
   end // [RQ9]

   assign pot_ctrl_o = pot_ctrl_ff;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   a_preset_wiper: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pwr_ff == PWR_SETTLE |-> wiper_ff[0] == WIPER_PRESET) // [RQ2]
      else $error("wiper not preset during power-up");
   a_vol_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !ready |-> !vol_ff) // [RQ7]
      else $error("volatile select set before ready");
   a_shutdown_tap: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !run_ff ##2 !run_ff |-> !pot_ctrl_o.run && pot_ctrl_o.tap0 == 7'h00)
      // [RQ9]
      else $error("shutdown did not park wiper low");
   a_busy_blocks: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_evt && busy_ff |=> $stable(wiper_ff[0]) && $stable(vol_ff)
      && $stable(run_ff)) // [RQ11]
      else $error("write accepted while busy");
   a_busy_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
      nv_commit |=> busy_ff [*8]) // [RQ23]
      else $error("busy too short");
   a_ptr_wrap: assert property (@(posedge clk_i) disable iff (!rstn_i)
      evt_new && evt_ff.kind != EVT_ADDR && ptr_ff == ADDR_ACR
      |=> ptr_ff == ADDR_POT0) // [RQ21]
      else $error("pointer did not wrap");
   a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ptr_ff == ADDR_RSVD [*3] |-> rd_byte_ff == 8'h00) // [RQ24]
      else $error("reserved byte not zero");
   a_ivr_to_wiper: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_ok && !vol_ff && ptr_ff == ADDR_POT1
      |=> wiper_ff[1] == $past(evt_ff.data[6:0])) // [RQ6]
      else $error("wiper not updated with initial value");
   a_quiet_powerup: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !ready |-> !sda_oe_o) // [RQ20]
      else $error("data pin driven during power-up");
   a_ack_slot: assert property (@(posedge scl_i) disable iff (!link_rst_n)
      sda_oe_ff && lstate_ff != LNK_RDATA |-> cnt_ff == BIT_ACK) // [RQ16]
      else $error("data driven outside acknowledge slot");
   a_id_reject: assert property (@(posedge scl_i) disable iff (!link_rst_n)
      byte_done && lstate_ff == LNK_ID && !id_match
      |=> lstate_ff == LNK_IGNORE && !ack_ff) // [RQ25]
      else $error("foreign id acknowledged");

   c_write_byte: cover property (@(posedge clk_i) disable iff (!rstn_i)
      wr_ok);
   c_read_byte: cover property (@(posedge clk_i) disable iff (!rstn_i)
      evt_new && evt_ff.kind == EVT_RDATA);
   c_nv_commit: cover property (@(posedge clk_i) disable iff (!rstn_i)
      nv_commit);
endmodule

// file: tb/two_wire_master.sv
/*
 Behavioural two-wire bus master that drives the slave's serial pins.
 Assumes an external pull-up: the bench resolves the wire from the
 master's pull-low and the slave's output enable.
*/
`timescale 1ns/1ps
module two_wire_master
#(
   parameter time Q = 36ns
)
(
   output logic      scl_o,
   output logic      sda_low_o,
   input  wire logic sda_i
);
   // ****************************************
   // Idle bus: both lines released high
   // ****************************************
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Also serves as repeated start, entered with the clock low
   task automatic start_cond();
      sda_low_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      #Q;
      sda_low_o = 1'b1;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask

   task automatic stop_cond();
      sda_low_o = 1'b1;
      #Q;
      scl_o = 1'b1;
      #Q;
      sda_low_o = 1'b0;
      #Q;
   endtask

   // Quarter steps keep the clock high long enough for the slave
   task automatic clock_bit(input logic b, output logic s);
      sda_low_o = ~b;
      #Q;
      scl_o = 1'b1;
      #Q;
      s = sda_i;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask

   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clock_bit(v[i], s);
      clock_bit(1'b1, ack);
   endtask

   // last high sends no-acknowledge to end a read
   task automatic get_byte(input logic last, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--)
         clock_bit(1'b1, v[i]);
      clock_bit(last, s);
   endtask
endmodule

// file: tb/dual_pot_slave_bench.sv
/*
 Self-checking bench for the dual potentiometer slave.
 Assumes the two-wire master model and a pull-up on the data wire.
*/
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module dual_pot_slave_bench;
   import dual_pot_pkg::*;
   // Short storage write keeps the run brief
   localparam int NV_CYC = 4000;
   logic         clk_i;
   logic         rstn_i;
   logic         scl;
   logic         sda_low;
   logic         sda_oe;
   logic         sda_out;
   logic         run_enable_n;
   logic [2:0]   strap;
   wire          sda_wire;
   pot_ctrl_type pot;
   logic [7:0]   rdv [0:2];
   logic         ack;
   int           failures;
   int           samples_checked;
   int           cycles;

   // ****************************************
   // Wire, clock, instances
   // ****************************************
   assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   dual_pot_slave #(.NV_WRITE_CYCLES(NV_CYC)) uut (
      .clk_i             (clk_i),
      .rstn_i            (rstn_i),
      .scl_i             (scl),
      .sda_i             (sda_wire),
      .sda_o             (sda_out),
      .sda_oe_o          (sda_oe),
      .addr_strap_pins_i (strap),
      .run_enable_n_i    (run_enable_n),
      .pot_ctrl_o        (pot)
   );

   two_wire_master m (
      .scl_o     (scl),
      .sda_low_o (sda_low),
      .sda_i     (sda_wire)
   );

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic open_to(input logic [7:0] a);
      m.start_cond();
      m.put_byte({ID_PREFIX, strap, 1'b0}, ack);
      `CHK("id ack", 1'b0, ack)
      m.put_byte(a, ack);
      `CHK("addr ack", 1'b0, ack)
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d,
                     input int n);
      open_to(a);
      for (int i = 0; i < n; i++)
      begin
         m.put_byte(d[15 - 8 * i -: 8], ack);
         `CHK("data ack", 1'b0, ack)
      end
      m.stop_cond();
   endtask

   task automatic rd(input logic [7:0] a, input int n);
      open_to(a);
      m.start_cond();
      m.put_byte({ID_PREFIX, strap, 1'b1}, ack);
      `CHK("read id ack", 1'b0, ack)
      for (int i = 0; i < n; i++)
         m.get_byte(i == n - 1, rdv[i]);
      m.stop_cond();
   endtask

   // Ends off the clock grid so serial pins never race the synchronisers
   task automatic settle();
      repeat (8) @(negedge clk_i);
      #1ns;
   endtask

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      rstn_i = 1'b0;
      run_enable_n = 1'b1;
      strap = 3'h5;
      repeat (5) @(negedge clk_i);
      rstn_i = 1'b1;
      #1ns;
      m.start_cond();
      m.put_byte({ID_PREFIX, strap, 1'b0}, ack);
      `CHK("power-up start", 1'b1, ack)
      m.stop_cond();
      #2500ns;
      settle();
      `CHK("sda idle", 1'b0, sda_oe)
      `CHK("power-up taps", {1'b1, 7'h40, 7'h40}, pot)
      rd(8'h08, 1);
      `CHK("control reset", 8'h40, rdv[0])
      wr(8'h08, 16'hff00, 1);
      rd(8'h08, 1);
      `CHK("control low bits", 8'hc0, rdv[0])
      wr(8'h00, 16'h7f00, 2);
      settle();
      `CHK("wipers", {1'b1, 7'h00, 7'h7f}, pot)
      rd(8'h00, 2);
      `CHK("wiper 0", 8'h7f, rdv[0])
      `CHK("wiper 1", 8'h00, rdv[1])
      wr(8'h08, 16'h8000, 1);
      settle();
      `CHK("run bit off", {1'b0, 14'h0}, pot)
      rd(8'h00, 1);
      `CHK("shutdown read", 8'h7f, rdv[0])
      wr(8'h08, 16'hc000, 1);
      @(negedge clk_i);
      run_enable_n = 1'b0;
      settle();
      `CHK("pin off", {1'b0, 14'h0}, pot)
      @(negedge clk_i);
      run_enable_n = 1'b1;
      settle();
      `CHK("restored", {1'b1, 7'h00, 7'h7f}, pot)
      m.start_cond();
      m.put_byte({ID_PREFIX, 3'h4, 1'b0}, ack);
      `CHK("foreign id", 1'b1, ack)
      m.put_byte(8'h00, ack);
      `CHK("ignored byte", 1'b1, ack)
      m.stop_cond();
      m.start_cond();
      m.put_byte({ID_PREFIX, strap, 1'b0}, ack);
      m.put_byte(8'h09, ack);
      `CHK("bad address", 1'b1, ack)
      m.stop_cond();
      wr(8'h08, 16'h4000, 1);
      wr(8'h01, 16'h2200, 1);
      settle();
      `CHK("initial to wiper", {1'b1, 7'h22, 7'h7f}, pot)
      rd(8'h08, 1);
      `CHK("busy", 8'h60, rdv[0])
      wr(8'h00, 16'h1100, 1);
      settle();
      `CHK("blocked", {1'b1, 7'h22, 7'h7f}, pot)
      repeat (NV_CYC) @(negedge clk_i);
      settle();
      rd(8'h07, 3);
      `CHK("reserved", 8'h00, rdv[0])
      `CHK("busy clear", 8'h40, rdv[1])
      `CHK("wrap", 8'h40, rdv[2])
      rd(8'h01, 1);
      `CHK("initial 1", 8'h22, rdv[0])
      wr(8'h03, 16'h5a00, 1);
      rd(8'h03, 1);
      `CHK("spare byte", 8'h5a, rdv[0])
      report_and_stop();
   end
endmodule
